// *** src/omr_pkg.sv ***
// Purpose: Shared constants and carrier types for the operating mode register block
// Assumes: 24-bit control word, core clock mclk at 20 MHz
// Notes: Field positions and reset values are named here and nowhere else

package omr_pkg;

	// ---------------------------------------------------------------
	// Register geometry
	// ---------------------------------------------------------------
	localparam int OMR_WIDTH = 24;                 // Whole register width
	localparam int OMR_SP_WIDTH = 6;               // Stack pointer counter bits incl. UF
	localparam int OMR_BOOT_LSB = 0;               // Boot mode bits 3..0
	localparam int OMR_BOOT_MSB = 3;
	localparam int OMR_PRIO_LSB = 8;               // Bus priority field 9..8
	localparam int OMR_PRIO_MSB = 9;
	localparam int OMR_MODE_MSB = 15;              // Top of the two mode bytes
	localparam int OMR_XYS_BIT = 16;               // Extension space select
	localparam int OMR_EUN_BIT = 17;               // Underflow flag
	localparam int OMR_EOV_BIT = 18;               // Overflow flag
	localparam int OMR_WRP_BIT = 19;               // Wrap flag
	localparam int OMR_SEN_BIT = 20;               // Extension enable
	localparam int OMR_RSV_LSB = 21;               // Reserved 23..21

	// Reset image of the non-boot bits, prio field ones
	localparam logic [23:0] OMR_RESET_VAL = 24'h000300;
	// Bits software may store, reserved and flag bits excluded
	localparam logic [23:0] OMR_WR_MASK = 24'h11FFFF;
	// Mask of both mode bytes
	localparam logic [23:0] OMR_MODE_MASK = 24'h00FFFF;
	localparam logic [5:0] OMR_SP_ZERO = 6'h00;     // Empty stack pointer value
	localparam logic [5:0] OMR_SP_ONE = 6'h01;      // Counter step

	// Write operation kind from the instruction decoder
	typedef enum logic [1:0] {
		OMR_OP_MOVE = 2'b00,                        // Control move: full write
		OMR_OP_AND = 2'b01,                         // And immediate
		OMR_OP_OR = 2'b10,                          // Or immediate
		OMR_OP_NONE = 2'b11                         // Idle
	} omr_op_t;

	// Instruction side request bundle
	typedef struct packed {
		logic wr;                                   // Explicit access strobe
		omr_op_t op;                                // Kind of explicit access
		logic [23:0] data;                          // Write data or immediate
	} omr_req_t;

	// Implicit stack traffic bundle
	typedef struct packed {
		logic push;                                 // Push requested
		logic pull;                                 // Pull requested
		logic wrap;                                 // Copy to extension begins
		logic [5:0] size;                           // Stack size register value
	} omr_stk_t;

	// All state of the block
	typedef struct packed {
		logic [23:0] omr;                           // The register itself
		logic [5:0] sp;                             // Stack pointer counter
		logic exc;                                  // Stack error exception pulse
		logic [3:0] pin_meta;                       // Mode pin synchroniser stage 1
		logic [3:0] pin_sync;                       // Mode pin synchroniser stage 2
	} omr_state_t;

endpackage : omr_pkg

// *** src/omr_ctrl.sv ***
// Purpose: Operating mode register with stack extension control and status
// Assumes: Mode pins are asynchronous, all requests come from core logic on mclk
// Notes: Boot bits load while rst_n is low through a two-stage pin synchroniser
//
// Behaviour
// - Readable writable 24-bit register, three bytes
// - Low bytes modes, top byte stack control
// - Mode bytes change only reset/explicit write
// - Stack byte touched implicitly and by any explicit write
// - Boot bits 3..0 captured from mode pins
// - Reserved bits 23..21 read zero
// - Enable bit 20, cleared by reset
// - Wrap flag sticky, set on copy start
// - Overflow on push when pointer equals size
// - Overflow rising raises level 3 exception
// - Underflow on pull when pointer zero
// - Underflow rising raises level 3 exception
// - Extended mode: underflow bit counts normally
// - Reset loads priority field ones, boot bits from pins, others zero
// - Bit 16 picks X or Y space

`timescale 1ns/1ns

module omr_ctrl (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] mode_pin,
	input wire omr_pkg::omr_req_t req,
	input wire omr_pkg::omr_stk_t stk,
	output logic [23:0] operating_mode_register,
	output logic [5:0] stack_pointer,
	output logic stack_error_exc,
	output logic stack_ext_space_y
);
	import omr_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	omr_state_t state_reg;                          // Registered state
	omr_state_t state_next;                         // Next state
	logic [23:0] wr_val;                            // Value an explicit write yields
	logic ovf_hit;                                  // Overflow condition
	logic unf_hit;                                  // Underflow condition
	logic move_wr;                                  // Control move to the register

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.exc = 1'b0;
		// Pins are outside the clock domain, two flops before any use
		state_next.pin_meta = mode_pin;
		state_next.pin_sync = state_reg.pin_meta;
		move_wr = req.wr && (req.op == OMR_OP_MOVE);
		case (req.op)
			OMR_OP_MOVE: begin
				wr_val = req.data;
			end
			OMR_OP_AND: begin
				wr_val = state_reg.omr & req.data;
			end
			OMR_OP_OR: begin
				wr_val = state_reg.omr | req.data;
			end
			default: begin
				wr_val = state_reg.omr;
			end
		endcase
		ovf_hit = stk.push && state_reg.omr[OMR_SEN_BIT] && (state_reg.sp == stk.size);
		unf_hit = stk.pull && state_reg.omr[OMR_SEN_BIT] && (state_reg.sp == OMR_SP_ZERO);
		if (req.wr) begin
			// store writable bits, reserved stay zero
			state_next.omr = (wr_val & OMR_WR_MASK) | (state_reg.omr & ~OMR_WR_MASK);
			// only a move clears the stack flags
			if (move_wr) begin
				state_next.omr[OMR_WRP_BIT] = 1'b0;
				state_next.omr[OMR_EOV_BIT] = 1'b0;
				state_next.omr[OMR_EUN_BIT] = 1'b0;
			end
		end
		// wrap flag set, set beats clear
		if (stk.wrap && state_reg.omr[OMR_SEN_BIT]) begin
			state_next.omr[OMR_WRP_BIT] = 1'b1;
		end
		if (ovf_hit) begin
			state_next.omr[OMR_EOV_BIT] = 1'b1;
		end
		if (unf_hit) begin
			state_next.omr[OMR_EUN_BIT] = 1'b1;
		end
		if ((ovf_hit && !state_reg.omr[OMR_EOV_BIT]) ||
			(unf_hit && !state_reg.omr[OMR_EUN_BIT])) begin
			state_next.exc = 1'b1;
		end
		// pointer counts through the underflow bit when extended
		if (stk.push && !stk.pull) begin
			state_next.sp = state_reg.sp + OMR_SP_ONE;
		end else if (stk.pull && !stk.push) begin
			state_next.sp = state_reg.sp - OMR_SP_ONE;
		end
		if (!state_reg.omr[OMR_SEN_BIT]) begin
			// Without extension the top bit is a plain underflow indicator
			if (stk.pull && !stk.push && state_reg.sp == OMR_SP_ZERO) begin
				state_next.sp = state_reg.sp;
				state_next.sp[OMR_SP_WIDTH-1] = 1'b1;
			end
		end
		state_next.omr[OMR_WIDTH-1:OMR_RSV_LSB] = '0;
		if (!rst_n) begin
			state_next.omr = OMR_RESET_VAL;
			state_next.sp = OMR_SP_ZERO;
			state_next.exc = 1'b0;
			// Synchroniser keeps running so the pins settle during reset
			// Boot bits are three edges late, so hold reset at least three edges
			// boot bits follow the synchronised pins during reset
			state_next.omr[OMR_BOOT_MSB:OMR_BOOT_LSB] = state_reg.pin_sync;
		end
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	// Reset handled in the next-state logic so boot bits load from pins
	always_ff @(posedge mclk) begin
		state_reg <= state_next;
	end

	// ---------------------------------------------------------------
	// Outputs, straight from flops
	// ---------------------------------------------------------------
	// whole word visible to the core
	assign operating_mode_register = state_reg.omr;
	assign stack_pointer = state_reg.sp;
	assign stack_error_exc = state_reg.exc;
	// space select straight from bit 16
	assign stack_ext_space_y = state_reg.omr[OMR_XYS_BIT];

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence s_ovf_cause;
		stk.push && state_reg.omr[OMR_SEN_BIT] && state_reg.sp == stk.size &&
			!state_reg.omr[OMR_EOV_BIT];
	endsequence

	AST_OVF_EXC: assert property (@(posedge mclk) disable iff (!rst_n)
		s_ovf_cause |=> stack_error_exc && operating_mode_register[OMR_EOV_BIT])
		else $error("overflow did not raise exception");

	AST_UNF_EXC: assert property (@(posedge mclk) disable iff (!rst_n)
		stk.pull && state_reg.omr[OMR_SEN_BIT] && state_reg.sp == OMR_SP_ZERO &&
		!state_reg.omr[OMR_EUN_BIT] |=> stack_error_exc && operating_mode_register[OMR_EUN_BIT])
		else $error("underflow did not raise exception");

	AST_RSV_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
		operating_mode_register[OMR_WIDTH-1:OMR_RSV_LSB] == 3'h0)
		else $error("reserved bits not zero");

	// Boot bits are left out, they follow the pins
	AST_RESET_IMG: assert property (@(posedge mclk)
		$past(!rst_n) |-> operating_mode_register[OMR_WIDTH-1:OMR_BOOT_MSB+1] ==
		OMR_RESET_VAL[OMR_WIDTH-1:OMR_BOOT_MSB+1])
		else $error("reset image wrong");

	// Waits until the synchroniser has filled after the start of reset
	AST_BOOT_PINS: assert property (@(posedge mclk)
		$past(!rst_n) && $past(!rst_n, 3) |->
		operating_mode_register[OMR_BOOT_MSB:OMR_BOOT_LSB] == $past(state_reg.pin_sync))
		else $error("boot bits not from pins");

	AST_NO_FLAG_DIS: assert property (@(posedge mclk) disable iff (!rst_n)
		!state_reg.omr[OMR_SEN_BIT] && !req.wr |=>
		$stable(operating_mode_register[OMR_WRP_BIT:OMR_EUN_BIT]))
		else $error("flag set while disabled");

	AST_MODE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
		!req.wr |=> $stable(operating_mode_register[OMR_MODE_MSB:0]))
		else $error("mode bytes changed without write");

	AST_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
		operating_mode_register[OMR_EOV_BIT] && !move_wr |=>
		operating_mode_register[OMR_EOV_BIT] [*1])
		else $error("overflow flag dropped");

	// Space select follows what a move stored
	AST_SPACE: assert property (@(posedge mclk) disable iff (!rst_n)
		move_wr |=> stack_ext_space_y == $past(req.data[OMR_XYS_BIT]))
		else $error("space select mismatch");

	// Move with no stack traffic in the same cycle
	sequence s_move_quiet;
		move_wr && !stk.push && !stk.pull && !stk.wrap;
	endsequence

	// A plain move leaves all three flags clear
	AST_MOVE_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
		s_move_quiet |=> operating_mode_register[OMR_WRP_BIT:OMR_EUN_BIT] == 3'h0)
		else $error("move did not clear flags");

	// Copy start with the extension on raises the wrap flag
	AST_WRAP_SET: assert property (@(posedge mclk) disable iff (!rst_n)
		stk.wrap && state_reg.omr[OMR_SEN_BIT] |=>
		operating_mode_register[OMR_WRP_BIT])
		else $error("wrap flag not set");

	// Underflow flag survives everything but a move
	AST_UNF_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
		operating_mode_register[OMR_EUN_BIT] && !move_wr |=>
		operating_mode_register[OMR_EUN_BIT])
		else $error("underflow flag dropped");

	// Extended mode pull wraps through the top pointer bit like any count
	AST_SP_COUNT: assert property (@(posedge mclk) disable iff (!rst_n)
		state_reg.omr[OMR_SEN_BIT] && stk.pull && !stk.push |=>
		stack_pointer == $past(stack_pointer) - OMR_SP_ONE)
		else $error("pointer did not count down");

endmodule : omr_ctrl

// *** test/tb_omr_ctrl.sv ***
// Purpose: Self-checking bench for omr_ctrl against a reference model
// Assumes: Inputs change 1 ns after the rising edge, 12-cycle reset
// Notes: Stack events are kept off write cycles in random traffic, enable timing is ambiguous

`timescale 1ns/1ns

module tb_omr_ctrl;
	import omr_pkg::*;

	// -----------------------------------------------------------
	// Signals and model state
	// -----------------------------------------------------------
	logic mclk;
	logic rst_n;
	logic [3:0] mode_pin;
	omr_req_t req;
	omr_stk_t stk;
	logic [23:0] omr_q;
	logic [5:0] sp_q;
	logic exc_q;
	logic spy_q;
	int fail_count;
	int tests_run;
	logic [31:0] seed; // Xorshift state
	logic [23:0] m_omr; // Model register
	logic [5:0] m_sp; // Model pointer
	logic m_exc; // Model exception pulse

	omr_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .mode_pin(mode_pin), .req(req), .stk(stk),
		.operating_mode_register(omr_q), .stack_pointer(sp_q), .stack_error_exc(exc_q),
		.stack_ext_space_y(spy_q));

	// Free running core clock, 50 ns
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// -----------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic chk;
		cmp(omr_q, m_omr, "register");
		cmp(sp_q, m_sp, "pointer");
		cmp(exc_q, m_exc, "exception");
		cmp(spy_q, m_omr[16], "space");
	endtask : chk

	// One request cycle; model built from the old enable bit
	task automatic step(input logic wr, input omr_op_t op, input logic [23:0] d,
		input logic pu, input logic pl, input logic wp, input logic [5:0] sz);
		logic [23:0] n;
		logic [2:0] f;
		req = '{wr, op, d};
		stk = '{pu, pl, wp, sz};
		n = m_omr;
		if (wr && op == OMR_OP_MOVE) n = d & OMR_WR_MASK;
		else if (wr && op == OMR_OP_AND) n = m_omr & (~OMR_WR_MASK | d);
		else if (wr && op == OMR_OP_OR) n = m_omr | (d & OMR_WR_MASK);
		f = {wp, pu && m_sp == sz, pl && m_sp == 6'h00} & {3{m_omr[20]}};
		n[19:17] = n[19:17] | f;
		m_exc = (n[18] & ~m_omr[18]) | (n[17] & ~m_omr[17]);
		if (pu && !pl) m_sp = m_sp + 6'h01;
		else if (pl && !pu) m_sp = (m_sp == 6'h00 && !m_omr[20]) ? 6'h20 : m_sp - 6'h01;
		m_omr = n;
		@(posedge mclk);
		#1;
		chk;
	endtask : step

	task automatic idle;
		step(1'b0, OMR_OP_NONE, 24'h000000, 1'b0, 1'b0, 1'b0, 6'h00);
	endtask : idle

	// Reset long enough for the pin synchroniser
	task automatic do_reset(input logic [3:0] pins);
		rst_n = 1'b0;
		mode_pin = pins;
		req = '{1'b0, OMR_OP_NONE, 24'h000000};
		stk = '{1'b0, 1'b0, 1'b0, 6'h00};
		repeat (12) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		m_omr = OMR_RESET_VAL | {20'h00000, pins};
		m_sp = 6'h00;
		m_exc = 1'b0;
		chk;
	endtask : do_reset

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_sim

	// -----------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------
	initial begin
		fail_count = 0;
		tests_run = 0;
		seed = 32'h00000046;
		do_reset(4'hA);
		idle;
		// Disabled extension: no flags from any stack event
		step(1'b0, OMR_OP_NONE, 24'h0, 1'b0, 1'b1, 1'b0, 6'h00);
		step(1'b0, OMR_OP_NONE, 24'h0, 1'b1, 1'b0, 1'b1, 6'h20);
		// Reserved bits dropped, immediates keep flags
		step(1'b1, OMR_OP_MOVE, 24'hFFFFFF, 1'b0, 1'b0, 1'b0, 6'h00);
		step(1'b1, OMR_OP_AND, 24'h000000, 1'b0, 1'b0, 1'b0, 6'h00);
		step(1'b1, OMR_OP_OR, 24'hFE0000, 1'b0, 1'b0, 1'b0, 6'h00);
		while (m_sp != 6'h00) step(1'b0, OMR_OP_NONE, 24'h0, 1'b0, 1'b1, 1'b0, 6'h3F);
		// Underflow, then overflow, then wrap
		step(1'b0, OMR_OP_NONE, 24'h0, 1'b0, 1'b1, 1'b0, 6'h3F);
		step(1'b0, OMR_OP_NONE, 24'h0, 1'b1, 1'b0, 1'b0, 6'h3F);
		step(1'b0, OMR_OP_NONE, 24'h0, 1'b0, 1'b0, 1'b1, 6'h00);
		step(1'b1, OMR_OP_AND, 24'h100000, 1'b0, 1'b0, 1'b0, 6'h00);
		step(1'b1, OMR_OP_MOVE, 24'h110000, 1'b1, 1'b0, 1'b0, m_sp);
		step(1'b1, OMR_OP_MOVE, 24'h110000, 1'b0, 1'b0, 1'b0, 6'h00);
		// Random traffic, stack events only on idle cycles
		repeat (3000) begin
			logic w;
			seed = xs(seed);
			w = seed[2:0] == 3'h0;
			step(w, omr_op_t'(seed[4:3]), seed[31:8], !w && seed[6:5] == 2'h0,
				!w && seed[10:9] == 2'h0, !w && seed[15:12] == 4'h0, {3'h0, seed[19:17]});
		end
		do_reset(4'h5);
		idle;
		end_sim;
	end

	// Watchdog well past the expected run
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_sim;
	end

endmodule : tb_omr_ctrl
